// ==== core/gport_pkg.sv ====
// Shared constants and types for the graphics port request and flow control master
package gport_pkg;

  // Command code and all-on byte-enable value on the byte-enable lines
  localparam logic [3:0] CMD_DAC         = 4'hd;
  localparam logic [3:0] BE_ALL_ON       = 4'h0;

  // Grant status codes seen with the bus grant
  localparam logic [2:0] ST_LP_READ      = 3'h0;
  localparam logic [2:0] ST_HP_READ      = 3'h1;
  localparam logic [2:0] ST_LP_WRITE     = 3'h2;
  localparam logic [2:0] ST_HP_WRITE     = 3'h3;
  localparam logic [2:0] ST_START_REQ    = 3'h7;

  // Flow control block: four clocks, throttle only on its last beat
  localparam logic [1:0] BLOCK_LAST      = 2'h3;

  // Request slots the master itself can track
  localparam logic [7:0] MASTER_CAPACITY = 8'h10;

  // Register offsets
  localparam logic [7:0] REG_COMMAND     = 8'h00;
  localparam logic [7:0] REG_STATUS      = 8'h04;

  // Command register fields and reset value
  localparam int         ADDR64_EN_BIT   = 5;
  localparam int         DEPTH_LSB       = 24;
  localparam logic [7:0] DEPTH_RESET     = 8'h00;

  // Status register fields
  localparam int         STAT_CAP_LSB    = 8;
  localparam int         STAT_TRUNC_BIT  = 16;
  localparam int         STAT_ENQ_BIT    = 17;
  localparam int         STAT_DATA_BIT   = 18;

  typedef enum logic [2:0] {
    E_IDLE = 3'b000,
    E_ARB  = 3'b001,
    E_SEND = 3'b010,
    E_HI   = 3'b011,
    E_TAIL = 3'b100
  } enq_state_t;

  typedef enum logic [1:0] {
    D_IDLE = 2'b00,
    D_ANN  = 2'b01,
    D_XFER = 2'b10,
    D_GAP  = 2'b11
  } data_state_t;

endpackage

// ==== core/gport_master.sv ====
// Graphics port master: pipelined request enqueue on AD, slot counting, data flow control

`timescale 1ns/1ns
`default_nettype none

module gport_master (
  // Clock and reset
  input  wire logic        sys_clk,
  input  wire logic        rst_n,
  // Register port
  input  wire logic [7:0]  reg_addr,
  input  wire logic [31:0] reg_wdata,
  input  wire logic        reg_we,
  input  wire logic        reg_re,
  output logic      [31:0] reg_rdata,
  // Request source
  input  wire logic        req_valid,
  output logic             req_ready,
  input  wire logic [63:0] req_addr,
  input  wire logic [2:0]  req_len,
  input  wire logic [3:0]  req_cmd,
  input  wire logic        req_last,
  // Data side
  input  wire logic [5:0]  xfer_clocks,
  input  wire logic [31:0] wr_data,
  input  wire logic        wr_data_ready,
  output logic             wr_data_take,
  output logic      [31:0] rd_data,
  output logic             rd_valid,
  input  wire logic        rd_stall,
  input  wire logic        rd_buf_full,
  input  wire logic        wr_buf_full,
  // Port pins
  output logic             bus_req_n,
  output logic             pipe_n,
  input  wire logic        gnt_n,
  input  wire logic [2:0]  grant_status_code,
  input  wire logic [31:0] ad_i,
  output logic      [31:0] ad_o,
  output logic             ad_oe_n,
  output logic      [3:0]  cbe_o,
  output logic             cbe_oe_n,
  output logic             irdy_n,
  input  wire logic        trdy_n,
  output logic             read_buffer_full_n,
  output logic             write_buffer_full_n
);
  function automatic logic is_data_code(input logic [2:0] st);
    is_data_code = (st == gport_pkg::ST_LP_READ) || (st == gport_pkg::ST_HP_READ) ||
                   (st == gport_pkg::ST_LP_WRITE) || (st == gport_pkg::ST_HP_WRITE);
  endfunction
  function automatic logic is_write_code(input logic [2:0] st);
    is_write_code = (st == gport_pkg::ST_LP_WRITE) || (st == gport_pkg::ST_HP_WRITE);
  endfunction

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  gport_pkg::enq_state_t  estate_q;
  gport_pkg::data_state_t dstate_q;
  logic        addr64_en_q;
  logic [7:0]  depth_q;
  logic        trunc_q;
  logic [7:0]  cnt_q;
  logic [7:0]  limit;
  logic        egrant, dgrant, take, free, use_dac, last_req, trunc_evt;
  logic        pipe_n_q, bus_req_n_q, ad_oe_n_q, cbe_oe_n_q;
  logic [31:0] ad_q, hi_addr_q, rdata_q, rd_data_q;
  logic [3:0]  cbe_q, hi_cmd_q;
  logic        hi_last_q, rd_valid_q, rbf_n_q, wbf_n_q;
  logic        is_write_q, is_lp_read_q, first_q, waited_q;
  logic [5:0]  rem_q;
  logic [1:0]  blk_q;
  logic        beat, last_beat, wr_load, to_gap, ann_go;
  // Capacity cap keeps a generous software depth from overrunning our own tracking
  assign limit     = (depth_q > gport_pkg::MASTER_CAPACITY) ?
                     gport_pkg::MASTER_CAPACITY : depth_q;
  assign egrant    = !gnt_n && (grant_status_code == gport_pkg::ST_START_REQ);
  assign dgrant    = !gnt_n && is_data_code(grant_status_code) && (dstate_q == gport_pkg::D_IDLE);
  assign req_ready = ((estate_q == gport_pkg::E_ARB) && egrant) ||
                     (estate_q == gport_pkg::E_SEND);
  assign take      = req_valid && req_ready;
  assign use_dac   = addr64_en_q && (req_addr[63:32] != 32'h0);
  assign trunc_evt = take && !addr64_en_q && (req_addr[63:32] != 32'h0);
  // Closing early when the next slot would hit the limit keeps the queue from overflowing
  assign last_req  = req_last || ((cnt_q + 8'h1) >= limit);
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      estate_q    <= gport_pkg::E_IDLE;
      pipe_n_q    <= 1'b1;
      bus_req_n_q <= 1'b1;
      hi_addr_q   <= 32'h0;
      hi_cmd_q    <= 4'h0;
      hi_last_q   <= 1'b0;
    end else begin
      case (estate_q)
        gport_pkg::E_IDLE: begin
          if (req_valid && (cnt_q < limit)) begin
            estate_q    <= gport_pkg::E_ARB;
            bus_req_n_q <= 1'b0;
          end
        end
        gport_pkg::E_ARB, gport_pkg::E_SEND: begin
          if (take) begin
            pipe_n_q    <= 1'b0;
            bus_req_n_q <= last_req && !use_dac;
            hi_addr_q   <= req_addr[63:32];
            hi_cmd_q    <= req_cmd;
            hi_last_q   <= last_req;
            if (use_dac) begin
              estate_q <= gport_pkg::E_HI;
            end else if (last_req) begin
              estate_q <= gport_pkg::E_TAIL;
            end else begin
              estate_q <= gport_pkg::E_SEND;
            end
          end
        end
        gport_pkg::E_HI: begin
          bus_req_n_q <= hi_last_q;
          estate_q    <= hi_last_q ? gport_pkg::E_TAIL : gport_pkg::E_SEND;
        end
        gport_pkg::E_TAIL: begin
          pipe_n_q <= 1'b1;
          estate_q <= gport_pkg::E_IDLE;
        end
        default: estate_q <= gport_pkg::E_IDLE;
      endcase
    end
  end
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      ad_q       <= 32'h0;
      cbe_q      <= 4'h0;
      ad_oe_n_q  <= 1'b1;
      cbe_oe_n_q <= 1'b1;
    end else if (take) begin
      ad_q       <= {req_addr[31:3], req_len};
      cbe_q      <= use_dac ? gport_pkg::CMD_DAC : req_cmd;
      ad_oe_n_q  <= 1'b0;
      cbe_oe_n_q <= 1'b0;
    end else if (estate_q == gport_pkg::E_HI) begin
      ad_q  <= hi_addr_q;
      cbe_q <= hi_cmd_q;
    end else if (estate_q == gport_pkg::E_TAIL) begin
      ad_oe_n_q  <= 1'b1;
      cbe_oe_n_q <= 1'b1;
    end else if (wr_load) begin
      ad_q       <= wr_data;
      cbe_q      <= gport_pkg::BE_ALL_ON;
      ad_oe_n_q  <= 1'b0;
      cbe_oe_n_q <= 1'b0;
    end else if (last_beat && is_write_q) begin
      ad_oe_n_q  <= 1'b1;
      cbe_oe_n_q <= 1'b1;
    end
  end
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      cnt_q <= 8'h0;
    end else begin
      case ({take, free})
        2'b10:   cnt_q <= cnt_q + 8'h1;
        2'b01:   cnt_q <= cnt_q - 8'h1;
        default: cnt_q <= cnt_q;
      endcase
    end
  end
  assign beat      = (dstate_q == gport_pkg::D_XFER) && !trdy_n;
  assign last_beat = beat && (rem_q == 6'h1);
  // Only low priority reads may pause, and only after the fourth beat of a block
  assign to_gap    = beat && !last_beat && (blk_q == gport_pkg::BLOCK_LAST) &&
                     is_lp_read_q && rd_stall;
  assign ann_go    = !is_write_q || wr_data_ready || waited_q;
  assign wr_load   = is_write_q && (((dstate_q == gport_pkg::D_ANN) && ann_go) ||
                     (beat && !last_beat));
  // Each granted data transfer frees one request slot on its first data beat
  assign free      = beat && first_q;

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      dstate_q     <= gport_pkg::D_IDLE;
      is_write_q   <= 1'b0;
      is_lp_read_q <= 1'b0;
      first_q      <= 1'b0;
      waited_q     <= 1'b0;
      rem_q        <= 6'h0;
      blk_q        <= 2'h0;
    end else begin
      case (dstate_q)
        gport_pkg::D_IDLE: begin
          if (dgrant) begin
            dstate_q     <= gport_pkg::D_ANN;
            is_write_q   <= is_write_code(grant_status_code);
            is_lp_read_q <= (grant_status_code == gport_pkg::ST_LP_READ);
            first_q      <= 1'b1;
            waited_q     <= 1'b0;
            rem_q        <= (xfer_clocks == 6'h0) ? 6'h1 : xfer_clocks;
            blk_q        <= 2'h0;
          end
        end
        gport_pkg::D_ANN: begin
          if (ann_go) begin
            dstate_q <= gport_pkg::D_XFER;
          end else begin
            waited_q <= 1'b1;
          end
        end
        gport_pkg::D_XFER: begin
          if (beat) begin
            first_q <= 1'b0;
            rem_q   <= rem_q - 6'h1;
            blk_q   <= blk_q + 2'h1;
            if (last_beat) begin
              dstate_q <= gport_pkg::D_IDLE;
            end else if (to_gap) begin
              dstate_q <= gport_pkg::D_GAP;
            end
          end
        end
        gport_pkg::D_GAP: begin
          if (!rd_stall) begin
            dstate_q <= gport_pkg::D_XFER;
          end
        end
        default: dstate_q <= gport_pkg::D_IDLE;
      endcase
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      rd_data_q  <= 32'h0;
      rd_valid_q <= 1'b0;
    end else begin
      rd_valid_q <= beat && !is_write_q;
      if (beat && !is_write_q) begin
        rd_data_q <= ad_i;
      end
    end
  end

  // Buffer-full levels are registered so the arbiter sees clean pin timing
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      rbf_n_q <= 1'b1;
      wbf_n_q <= 1'b1;
    end else begin
      rbf_n_q <= !rd_buf_full;
      wbf_n_q <= !wr_buf_full;
    end
  end
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      addr64_en_q <= 1'b0;
      depth_q     <= gport_pkg::DEPTH_RESET;
    end else if (reg_we && (reg_addr == gport_pkg::REG_COMMAND)) begin
      addr64_en_q <= reg_wdata[gport_pkg::ADDR64_EN_BIT];
      depth_q     <= reg_wdata[gport_pkg::DEPTH_LSB +: 8];
    end
  end

  // A new truncation in the clearing cycle wins over the clear
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      trunc_q <= 1'b0;
    end else if (trunc_evt) begin
      trunc_q <= 1'b1;
    end else if (reg_we && (reg_addr == gport_pkg::REG_STATUS) &&
                 reg_wdata[gport_pkg::STAT_TRUNC_BIT]) begin
      trunc_q <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      rdata_q <= 32'h0;
    end else if (reg_re) begin
      rdata_q <= 32'h0;
      case (reg_addr)
        gport_pkg::REG_COMMAND: begin
          rdata_q[gport_pkg::ADDR64_EN_BIT]   <= addr64_en_q;
          rdata_q[gport_pkg::DEPTH_LSB +: 8]  <= depth_q;
        end
        gport_pkg::REG_STATUS: begin
          rdata_q[7:0]                        <= cnt_q;
          rdata_q[gport_pkg::STAT_CAP_LSB +: 8] <= gport_pkg::MASTER_CAPACITY;
          rdata_q[gport_pkg::STAT_TRUNC_BIT]  <= trunc_q;
          rdata_q[gport_pkg::STAT_ENQ_BIT]    <= (estate_q != gport_pkg::E_IDLE);
          rdata_q[gport_pkg::STAT_DATA_BIT]   <= (dstate_q != gport_pkg::D_IDLE);
        end
        default: rdata_q <= 32'h0;
      endcase
    end
  end

  assign reg_rdata           = rdata_q;
  assign bus_req_n           = bus_req_n_q;
  assign pipe_n              = pipe_n_q;
  assign ad_o                = ad_q;
  assign ad_oe_n             = ad_oe_n_q;
  assign cbe_o               = cbe_q;
  assign cbe_oe_n            = cbe_oe_n_q;
  assign irdy_n              = (dstate_q != gport_pkg::D_XFER);
  assign wr_data_take        = wr_load;
  assign rd_data             = rd_data_q;
  assign rd_valid            = rd_valid_q;
  assign read_buffer_full_n  = rbf_n_q;
  assign write_buffer_full_n = wbf_n_q;
  sequence dac_lo_s;
    !pipe_n_q && (cbe_q == gport_pkg::CMD_DAC) && !bus_req_n_q;
  endsequence
  sequence dac_hi_s;
    !pipe_n_q && (cbe_q != gport_pkg::CMD_DAC) && !cbe_oe_n_q;
  endsequence
  pipe_per_req_a: assert property (take |=> !pipe_n_q && !ad_oe_n_q)
    else $error("pipe not active after a taken request");
  last_ends_a: assert property (!pipe_n_q && bus_req_n_q |=> pipe_n_q && ad_oe_n_q)
    else $error("pipe still active after final request");
  dac_enabled_a: assert property (!pipe_n_q && (cbe_q == gport_pkg::CMD_DAC)
    |-> addr64_en_q)
    else $error("dual address cycle sent while disabled");
  dac_pair_a: assert property ((estate_q == gport_pkg::E_HI) |-> dac_lo_s ##1 dac_hi_s)
    else $error("dual address request not two clocks");
  sac_low_a: assert property (take && (req_addr[63:32] == 32'h0)
    |=> cbe_q != gport_pkg::CMD_DAC)
    else $error("dual address used below 4 GB");
  no_gap_a: assert property (!pipe_n_q && !bus_req_n_q |=> !pipe_n_q)
    else $error("idle clock inside enqueue transaction");
  depth_cap_a: assert property (take |-> cnt_q < limit && cnt_q < gport_pkg::MASTER_CAPACITY)
    else $error("request issued beyond allowed depth");
  slot_free_a: assert property (free && !take |=> cnt_q == $past(cnt_q) - 8'h1)
    else $error("slot not returned on first data beat");
  count_hold_a: assert property (take && free |=> cnt_q == $past(cnt_q))
    else $error("counter moved on simultaneous take and free");
  block_edge_a: assert property ((dstate_q == gport_pkg::D_GAP) |-> blk_q == 2'h0 && is_lp_read_q)
    else $error("read stalled off a block boundary or on high priority");
  wr_hold_a: assert property ((dstate_q == gport_pkg::D_ANN) [*2] |=> dstate_q == gport_pkg::D_XFER)
    else $error("initial write block held more than one clock");
endmodule // gport_master

`default_nettype wire

// ==== testbench/corelogic_model.sv ====
// Corelogic model: request arbiter and data target facing the graphics port master
`timescale 1ns/1ns
`default_nettype none

module corelogic_model (
  // Clock and reset
  input  wire logic        sys_clk,
  input  wire logic        rst_n,
  // Master pins
  input  wire logic        bus_req_n,
  input  wire logic        pipe_n,
  input  wire logic        irdy_n,
  output logic             gnt_n,
  output logic      [2:0]  grant_status_code,
  output logic             trdy_n,
  output logic      [31:0] ad_i,
  // Bench commands a data grant
  input  wire logic        go,
  input  wire logic [2:0]  go_st,
  input  wire logic [5:0]  go_len
);
  logic       held_q;
  logic [5:0] left_q;

  // Request grants wait for any data transfer to finish, so the two never overlap
  always_ff @(posedge sys_clk) begin
    gnt_n <= 1'b1;
    if (!pipe_n) held_q <= 1'b0;
    if (!rst_n) begin
      held_q            <= 1'b0;
      grant_status_code <= gport_pkg::ST_START_REQ;
    end else if (go) begin
      gnt_n             <= 1'b0;
      grant_status_code <= go_st;
    end else if (!bus_req_n && pipe_n && !held_q && left_q == 6'h00) begin
      gnt_n             <= 1'b0;
      grant_status_code <= gport_pkg::ST_START_REQ;
      held_q            <= 1'b1;
    end
  end

  // Target side never drives a stale word: AD input changes every clock
  always_ff @(posedge sys_clk) begin
    ad_i <= ad_i + 32'h01010101;
    if (!rst_n) begin
      left_q <= 6'h00;
      trdy_n <= 1'b1;
      ad_i   <= 32'h5a5a5a5a;
    end else if (go) begin
      left_q <= go_len;
      trdy_n <= 1'b0;
    end else if (!irdy_n && !trdy_n) begin
      left_q <= left_q - 6'h01;
      if (left_q == 6'h01) trdy_n <= 1'b1;
    end
  end
endmodule // corelogic_model

`default_nettype wire

// ==== testbench/testbench.sv ====
// Self-checking bench for the graphics port master
`timescale 1ns/1ns
`default_nettype none

module testbench;
  logic        sys_clk, rst_n, reg_we, reg_re, req_valid, req_ready, req_last, go;
  logic        wr_data_ready, wr_data_take, rd_valid, rd_stall, rd_buf_full, wr_buf_full;
  logic        bus_req_n, pipe_n, gnt_n, ad_oe_n, cbe_oe_n, irdy_n, trdy_n;
  logic        read_buffer_full_n, write_buffer_full_n;
  logic [7:0]  reg_addr;
  logic [31:0] reg_wdata, reg_rdata, wr_data, rd_data, ad_i, ad_o, d;
  logic [63:0] req_addr;
  logic [2:0]  req_len, grant_status_code, go_st;
  logic [3:0]  req_cmd, cbe_o;
  logic [5:0]  xfer_clocks, go_len;
  logic [36:0] mon_q[$], exp_q[$];
  int          errors, checks_done, cyc, seed, b, s, low, f, tk;

  gport_master gport_master_i (.sys_clk, .rst_n, .reg_addr, .reg_wdata, .reg_we, .reg_re,
    .reg_rdata, .req_valid, .req_ready, .req_addr, .req_len, .req_cmd, .req_last,
    .xfer_clocks, .wr_data, .wr_data_ready, .wr_data_take, .rd_data, .rd_valid, .rd_stall,
    .rd_buf_full, .wr_buf_full, .bus_req_n, .pipe_n, .gnt_n, .grant_status_code, .ad_i,
    .ad_o, .ad_oe_n, .cbe_o, .cbe_oe_n, .irdy_n, .trdy_n, .read_buffer_full_n,
    .write_buffer_full_n);
  corelogic_model corelogic_model_i (.sys_clk, .rst_n, .bus_req_n, .pipe_n, .irdy_n, .gnt_n,
    .grant_status_code, .trdy_n, .ad_i, .go, .go_st, .go_len);

  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end

  // Every clock of an enqueue as {bus request, byte enables, AD}
  always @(posedge sys_clk) if (pipe_n === 1'b0) mon_q.push_back({bus_req_n, cbe_o, ad_o});

  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 20000) begin
      errors++;
      wrap_up();
    end
  end

  task automatic wrap_up();
    $display("checks %0d errors %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  task automatic chk(string what, logic [63:0] exp, logic [63:0] got);
    checks_done++;
    if (got !== exp) begin
      errors++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic wr(logic [7:0] a, logic [31:0] v);
    reg_we    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= v;
    @(posedge sys_clk);
    reg_we    <= 1'b0;
  endtask

  task automatic rd(logic [7:0] a);
    reg_re   <= 1'b1;
    reg_addr <= a;
    @(posedge sys_clk);
    reg_re   <= 1'b0;
    @(posedge sys_clk);
    d = reg_rdata;
  endtask

  task automatic chk_st(logic [7:0] n);
    rd(gport_pkg::REG_STATUS);
    chk("outstanding", n, d[7:0]);
  endtask

  // Offer n requests back to back; dac marks those given nonzero upper address bits
  task automatic burst(int n, logic [3:0] dac, logic en);
    logic [63:0] a;
    logic [3:0]  c;
    logic [2:0]  l;
    int          w;
    logic        lst;
    mon_q.delete();
    exp_q.delete();
    for (int i = 0; i < n; i++) begin
      a   = {(dac[i] ? ($random(seed) | 32'h1) : 32'h0), $random(seed)};
      c   = 4'h0 + ($random(seed) & 3);
      l   = $random(seed);
      lst = (i == n - 1);
      req_valid <= 1'b1;
      req_addr  <= a;
      req_cmd   <= c;
      req_len   <= l;
      req_last  <= lst;
      if (dac[i] && en) begin
        exp_q.push_back({1'b0, gport_pkg::CMD_DAC, a[31:3], l});
        exp_q.push_back({lst, c, a[63:32]});
      end else exp_q.push_back({lst, c, a[31:3], l});
      w = 0;
      do begin
        @(posedge sys_clk);
        w++;
      end while (req_ready !== 1'b1 && w < 200);
    end
    req_valid <= 1'b0;
    repeat (4) @(posedge sys_clk);
    chk("released", 2'b11, {ad_oe_n, cbe_oe_n});
    chk("words", exp_q.size(), mon_q.size());
    for (int i = 0; i < exp_q.size() && i < mon_q.size(); i++)
      chk("word", exp_q[i], mon_q[i]);
  endtask

  // Grant one data transfer; count beats and takes, check every word handed over
  task automatic dat(logic [2:0] st, logic [5:0] n);
    int          t;
    logic [31:0] ex;
    bit          pend;
    xfer_clocks <= n;
    go          <= 1'b1;
    go_st       <= st;
    go_len      <= n;
    @(posedge sys_clk);
    go <= 1'b0;
    b    = 0;
    f    = 0;
    tk   = 0;
    pend = 1'b0;
    ex   = 32'h0;
    // One extra clock after the last read beat lets its word be checked
    for (t = 1; t < 60 && (b < n || pend); t++) begin
      @(posedge sys_clk);
      if (t == 2) wr_data_ready <= 1'b1;
      if (t == 12) rd_stall <= 1'b0;
      if (pend) chk("rd word", {1'b1, ex}, {rd_valid, rd_data});
      pend = 1'b0;
      if (wr_data_take === 1'b1) tk++;
      if (irdy_n === 1'b0 && trdy_n === 1'b0) begin
        b++;
        if (b == 1) f = t;
        s = t - f + 1;
        if (st == gport_pkg::ST_LP_READ || st == gport_pkg::ST_HP_READ) begin
          pend = 1'b1;
          ex   = ad_i;
        end else begin
          chk("wr word", {1'b0, wr_data}, {ad_oe_n, ad_o});
        end
      end
    end
    repeat (3) @(posedge sys_clk);
  endtask

  initial begin
    seed = 32'he76b2b2b;
    {reg_we, reg_re, req_valid, req_last, go, rd_stall, rd_buf_full, wr_buf_full} = '0;
    {reg_addr, reg_wdata, req_addr, req_len, req_cmd, go_st, go_len, xfer_clocks} = '0;
    wr_data_ready = 1'b1;
    wr_data       = $random(seed);
    rst_n         = 1'b0;
    repeat (10) @(posedge sys_clk);
    rst_n <= 1'b1;
    @(posedge sys_clk);
    chk("idle pins", 2'b11, {pipe_n, bus_req_n});
    rd(gport_pkg::REG_STATUS);
    chk("capacity", gport_pkg::MASTER_CAPACITY, d[15:8]);
    rd(8'h40);
    chk("unmapped", 32'h0, d);
    wr(gport_pkg::REG_COMMAND, 32'h02000000);
    burst(2, 4'h0, 1'b0);
    chk_st(8'h02);
    req_valid <= 1'b1;
    low = 0;
    repeat (20) begin
      @(posedge sys_clk);
      if (bus_req_n !== 1'b1) low++;
    end
    req_valid <= 1'b0;
    chk("start at limit", 0, low);
    dat(gport_pkg::ST_LP_READ, 6'h02);
    chk("lp beats", 2, b);
    chk_st(8'h01);
    wr_data <= $random(seed);
    dat(gport_pkg::ST_LP_WRITE, 6'h06);
    chk("wr beats", 6, b);
    chk("wr takes", 6, tk);
    chk("wr start", 3, f);
    chk_st(8'h00);
    wr(gport_pkg::REG_COMMAND, 32'hff000020);
    burst(4, 4'b0110, 1'b1);
    chk_st(8'h04);
    rd_stall <= 1'b1;
    dat(gport_pkg::ST_HP_READ, 6'h08);
    chk("hp span", 8, s);
    rd_stall <= 1'b1;
    dat(gport_pkg::ST_LP_READ, 6'h08);
    chk("lp gap", 1'b1, s > 8);
    wr_data_ready <= 1'b0;
    wr_data       <= $random(seed);
    dat(gport_pkg::ST_HP_WRITE, 6'h03);
    chk("wr hold", 4, f);
    chk("hp wr takes", 3, tk);
    chk_st(8'h01);
    wr(gport_pkg::REG_COMMAND, 32'h10000000);
    burst(1, 4'b0001, 1'b0);
    rd(gport_pkg::REG_STATUS);
    chk("trunc flag", 1'b1, d[gport_pkg::STAT_TRUNC_BIT]);
    wr(gport_pkg::REG_STATUS, 32'h00010000);
    rd(gport_pkg::REG_STATUS);
    chk("trunc clear", 1'b0, d[gport_pkg::STAT_TRUNC_BIT]);
    rd_buf_full <= 1'b1;
    wr_buf_full <= 1'b1;
    repeat (2) @(posedge sys_clk);
    chk("rbf pin", 1'b0, read_buffer_full_n);
    chk("wbf pin", 1'b0, write_buffer_full_n);
    wrap_up();
  end
endmodule // testbench

`default_nettype wire
